/* File: logic/standard_event_status.sv */
/*
 standard event status register, its enable mask, completion and wait logic.
 assumes all inputs come from logic on sys_clk; queue entries arrive as
 single-cycle posts; the parser asserts a one-cycle strobe per command.
*/
`timescale 1ns/10ps
`default_nettype none
`include "event_status_defs.svh"
module standard_event_status (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic queuePost,
   input wire event_status_pkg::event_kind_type queueKind,
   input wire logic enableWrite,
   input wire event_status_pkg::reg16_type enableData,
   input wire logic statusRead,
   input wire logic opCompleteCmd,
   input wire logic waitToContinueCmd,
   input wire logic opsPending,
   output var event_status_pkg::reg16_type eventStatus,
   output var event_status_pkg::reg16_type eventStatusEnable,
   output logic eventSummary,
   output logic [7:0] statusByteSummary,
   output logic execStall
);
   import event_status_pkg::*;

   reg16_type status_r;
   reg16_type enable_r;
   reg16_type setBits;
   reg16_type readData_r;
   opc_state_type opcState_r;
   logic waiting_r;
   logic opcDone;

   function automatic reg16_type kindBits(input event_kind_type k);
      reg16_type b;
      b = '0;
      unique case (k)
         EV_NONE: b = '0;
         EV_DEVICE_FAULT: b[`ES_DEVICE_SPECIFIC_FAULT] = 1'b1;
         EV_EXEC_FAULT: b[`ES_EXECUTION_FAULT] = 1'b1;
         EV_CMD_FAULT: b[`ES_COMMAND_FAULT] = 1'b1;
      endcase
      return b;
   endfunction

   // completion waits from the cycle after the command until no operation is pending, then posts once
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         opcState_r <= OPC_IDLE;
      end else begin
         unique case (opcState_r)
            OPC_IDLE: if (opCompleteCmd) begin
               opcState_r <= OPC_ARMED;
            end
            OPC_ARMED: if (!opsPending) begin
               opcState_r <= OPC_IDLE;
            end
         endcase
      end
   end
   assign opcDone = (opcState_r == OPC_ARMED) && !opsPending;
   a_opc_needs_cmd: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      opcState_r == OPC_IDLE |-> !opcDone)
      else $error("completion without command");
   a_opc_once: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      opcDone |=> opcState_r == OPC_IDLE)
      else $error("completion stayed armed");

   always_comb begin
      setBits = queuePost ? kindBits(queueKind) : '0;
      setBits[`ES_OP_COMPLETE] = opcDone;
   end
   a_queue_only: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !queuePost && !opcDone && !statusRead
      |=> status_r == $past(status_r))
      else $error("event set without queue entry");
   a_device_fault: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      queuePost && queueKind == EV_DEVICE_FAULT
      |=> status_r[`ES_DEVICE_SPECIFIC_FAULT])
      else $error("device fault not logged");
   a_exec_fault: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      queuePost && queueKind == EV_EXEC_FAULT
      |=> status_r[`ES_EXECUTION_FAULT])
      else $error("execution fault not logged");
   a_cmd_fault: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      queuePost && queueKind == EV_CMD_FAULT
      |=> status_r[`ES_COMMAND_FAULT])
      else $error("command fault not logged");

   // read clears, new events win over the clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_r <= `ES_STATUS_RESET;
      end else if (statusRead) begin
         status_r <= setBits & `ES_IMPL_MASK;
      end else begin
         status_r <= (status_r | setBits) & `ES_IMPL_MASK;
      end
   end
   a_bus_request_zero: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !status_r[`ES_BUS_CONTROL_REQUEST])
      else $error("bus control request bit set");
   a_unprovided_zero: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !status_r[`ES_QUERY_FAULT] && !status_r[`ES_USER_REQUEST]
      && !status_r[`ES_POWER_ON_EVENT])
      else $error("unprovided event bit set");

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         readData_r <= `ES_STATUS_RESET;
      end else if (statusRead) begin
         readData_r <= status_r;
      end
   end
   assign eventStatus = readData_r;
   a_read_stands: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !statusRead |=> $stable(eventStatus))
      else $error("read value changed without read");

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_r <= `ES_ENABLE_RESET;
      end else if (enableWrite) begin
         enable_r <= enableData;
      end
   end
   assign eventStatusEnable = enable_r;
   a_mask_load: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      enableWrite |=> eventStatusEnable == $past(enableData))
      else $error("mask not loaded");
   a_mask_off_quiet: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      enable_r == `ES_ENABLE_RESET |-> !eventSummary)
      else $error("summary raised with cleared mask");

   assign eventSummary = |(status_r & enable_r);
   always_comb begin
      statusByteSummary = 8'h00;
      statusByteSummary[`STB_SUMMARY_BIT] = eventSummary;
   end
   a_unmasked_quiet: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !eventSummary && queuePost && queueKind == EV_CMD_FAULT
      && !enable_r[`ES_COMMAND_FAULT] && !enableWrite && !opcDone
      |=> !eventSummary)
      else $error("unmasked event raised summary");

   // wait stalls later commands until nothing is pending
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         waiting_r <= 1'b0;
      end else if (waitToContinueCmd && opsPending) begin
         waiting_r <= 1'b1;
      end else if (!opsPending) begin
         waiting_r <= 1'b0;
      end
   end
   assign execStall = (waiting_r || waitToContinueCmd) && opsPending;
   a_stall_drop: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !opsPending |-> !execStall)
      else $error("stall without pending work");
   a_wait_clears: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !opsPending |=> !waiting_r)
      else $error("wait state outlived pending work");

   a_summary_mask: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      eventSummary == |(status_r & enable_r))
      else $error("summary differs from masked status");
   a_exec_to_summary: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      queuePost && queueKind == EV_EXEC_FAULT && enable_r == 16'h0010
      && !enableWrite |=> eventSummary)
      else $error("exec fault did not raise summary");
   a_read_clears: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      statusRead |=> status_r == ($past(setBits) & `ES_IMPL_MASK)
      && eventStatus == $past(status_r))
      else $error("read did not return then clear");
   a_reserved_zero: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (status_r & ~`ES_IMPL_MASK) == 16'h0000)
      else $error("reserved event bit set");
   a_event_survives: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      statusRead && queuePost && queueKind == EV_CMD_FAULT
      |=> status_r[`ES_COMMAND_FAULT])
      else $error("event lost on clear");
   a_opc_waits: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      opsPending && !queuePost |=> !(status_r[`ES_OP_COMPLETE]
      && !$past(status_r[`ES_OP_COMPLETE])))
      else $error("completion posted while pending");
   a_opc_posts: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      opCompleteCmd && opcState_r == OPC_IDLE ##1 !opsPending && !statusRead
      |=> status_r[`ES_OP_COMPLETE])
      else $error("completion not posted");
   a_wait_stall: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      waitToContinueCmd && opsPending ##1 opsPending |-> execStall)
      else $error("wait did not stall");
   a_stb_bit: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      statusByteSummary == {2'b00, eventSummary, 5'b00000})
      else $error("status byte bit wrong");

   c_read_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
      status_r != 16'h0000 ##1 statusRead);
   c_opc_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
      opCompleteCmd ##[1:20] opcDone);
   c_wait: cover property (@(posedge sys_clk) disable iff (!rst_n)
      execStall ##[1:20] !execStall);
   c_summary: cover property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(eventSummary));
   c_event_survive: cover property (@(posedge sys_clk) disable iff (!rst_n)
      statusRead && queuePost);
endmodule
`default_nettype wire

/* File: pkg/event_status_defs.svh */
/*
 holds the width, bit positions, masks and reset values of the event status block.
 assumes it is included by bare name from the package and the design.
*/
`ifndef EVENT_STATUS_DEFS_SVH
`define EVENT_STATUS_DEFS_SVH
`define ES_WIDTH 16
`define ES_OP_COMPLETE 0
`define ES_BUS_CONTROL_REQUEST 1
`define ES_QUERY_FAULT 2
`define ES_DEVICE_SPECIFIC_FAULT 3
`define ES_EXECUTION_FAULT 4
`define ES_COMMAND_FAULT 5
`define ES_USER_REQUEST 6
`define ES_POWER_ON_EVENT 7
`define ES_IMPL_MASK 16'h0039
`define ES_ENABLE_RESET 16'h0000
`define ES_STATUS_RESET 16'h0000
`define STB_SUMMARY_BIT 5
`endif

/* File: pkg/event_status_pkg.sv */
/*
 types of the event status block.
 assumes event_status_defs.svh sits in the include path.
*/
`include "event_status_defs.svh"
package event_status_pkg;
   typedef logic [`ES_WIDTH-1:0] reg16_type;
   typedef enum logic [1:0] {
      EV_NONE,
      EV_DEVICE_FAULT,
      EV_EXEC_FAULT,
      EV_CMD_FAULT
   } event_kind_type;
   typedef enum {
      OPC_IDLE,
      OPC_ARMED
   } opc_state_type;
endpackage

/* File: dv/ctl_model.sv */
/*
 remote controller model: mask writes, status reads, completion and wait.
 assumes the bench calls its tasks and feeds eventStatus back to it.
*/
`timescale 1ns/10ps
`default_nettype none
module ctl_model (
   input wire logic sys_clk,
   input wire event_status_pkg::reg16_type eventStatus,
   output logic enableWrite,
   output var event_status_pkg::reg16_type enableData,
   output logic statusRead,
   output logic opCompleteCmd,
   output logic waitToContinueCmd
);
   import event_status_pkg::*;
   initial begin
      {enableWrite, statusRead, opCompleteCmd, waitToContinueCmd} = 4'h0;
      enableData = 16'h0000;
   end
   // mask is the sum of the wanted bit weights
   task automatic writeMask(input reg16_type m);
      @(posedge sys_clk);
      enableWrite <= 1'b1;
      enableData <= m;
      @(posedge sys_clk);
      enableWrite <= 1'b0;
      enableData <= ~m;
   endtask
   task automatic readStatus(output reg16_type v);
      @(posedge sys_clk);
      statusRead <= 1'b1;
      @(posedge sys_clk);
      statusRead <= 1'b0;
      #1 v = eventStatus;
   endtask
   task automatic command(input logic wt);
      @(posedge sys_clk);
      opCompleteCmd <= !wt;
      waitToContinueCmd <= wt;
      @(posedge sys_clk);
      {opCompleteCmd, waitToContinueCmd} <= 2'b00;
   endtask
endmodule
`default_nettype wire

/* File: dv/standard_event_status_tb.sv */
/*
 self-checking bench of standard_event_status.
 assumes ctl_model drives the command side; the bench posts queue entries.
*/
`timescale 1ns/10ps
`default_nettype none
module standard_event_status_tb;
   import event_status_pkg::*;
   logic sys_clk, rst_n, queuePost, opsPending, enableWrite, statusRead;
   logic opCompleteCmd, waitToContinueCmd, eventSummary, execStall;
   event_kind_type queueKind;
   reg16_type enableData, eventStatus, eventStatusEnable, v;
   logic [7:0] statusByteSummary;
   int error_cnt = 0, compares = 0, cycles = 0;
   standard_event_status standard_event_status_i (.sys_clk, .rst_n,
      .queuePost, .queueKind, .enableWrite, .enableData, .statusRead,
      .opCompleteCmd, .waitToContinueCmd, .opsPending, .eventStatus,
      .eventStatusEnable, .eventSummary, .statusByteSummary, .execStall);
   ctl_model ctl_model_i (.sys_clk, .eventStatus, .enableWrite,
      .enableData, .statusRead, .opCompleteCmd, .waitToContinueCmd);
   task automatic check(input string n, input reg16_type e,
      input reg16_type g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic post(input event_kind_type k);
      @(posedge sys_clk);
      queuePost <= 1'b1;
      queueKind <= k;
      @(posedge sys_clk);
      queuePost <= 1'b0;
      queueKind <= EV_NONE;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         close_out();
      end
   end
   initial begin
      {rst_n, queuePost, opsPending} = 3'b000;
      queueKind = EV_NONE;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1 check("enable", 16'h0000, eventStatusEnable);
      post(EV_DEVICE_FAULT);
      post(EV_EXEC_FAULT);
      post(EV_CMD_FAULT);
      ctl_model_i.readStatus(v);
      check("kinds", 16'h0038, v);
      ctl_model_i.readStatus(v);
      check("cleared", 16'h0000, v);
      $display("test kinds done");
      ctl_model_i.writeMask(16'h0010);
      #1 check("mask", 16'h0010, eventStatusEnable);
      post(EV_CMD_FAULT);
      #1 check("masked", 16'h0000, {15'h0, eventSummary});
      post(EV_EXEC_FAULT);
      #1 check("summary", 16'h0001, {15'h0, eventSummary});
      check("stb", 16'h0020, {8'h00, statusByteSummary});
      fork
         ctl_model_i.readStatus(v);
         post(EV_DEVICE_FAULT);
      join
      check("read", 16'h0030, v);
      ctl_model_i.readStatus(v);
      check("survive", 16'h0008, v);
      $display("test summary done");
      @(posedge sys_clk) opsPending <= 1'b1;
      ctl_model_i.command(1'b0);
      repeat (4) @(posedge sys_clk);
      ctl_model_i.readStatus(v);
      check("opc early", 16'h0000, v);
      @(posedge sys_clk) opsPending <= 1'b0;
      repeat (3) @(posedge sys_clk);
      ctl_model_i.readStatus(v);
      check("opc", 16'h0001, v);
      @(posedge sys_clk) opsPending <= 1'b1;
      ctl_model_i.command(1'b1);
      #1 check("stall", 16'h0001, {15'h0, execStall});
      @(posedge sys_clk) opsPending <= 1'b0;
      #1 check("go", 16'h0000, {15'h0, execStall});
      ctl_model_i.command(1'b0);
      repeat (2) @(posedge sys_clk);
      ctl_model_i.readStatus(v);
      check("opc idle", 16'h0001, v);
      $display("test completion done");
      @(posedge sys_clk) rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1 check("mask reset", 16'h0000, eventStatusEnable);
      $display("test reset done");
      close_out();
   end
endmodule
`default_nettype wire
